// *** logic/dps_map.vh ***
// Register map, field positions, reset values and timing counts of the path selector.
`ifndef DPS_MAP_VH
`define DPS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define DPS_ADDR_PATH_CTRL   8'h13

// ----------------------------------------------------------------------------
// Field positions of input_path_control
// ----------------------------------------------------------------------------
`define DPS_BIT_P1_STATUS    0
`define DPS_BIT_P2_STATUS    1
`define DPS_BIT_DIS_ALL      2
`define DPS_BIT_HIZ          3
`define DPS_BIT_GLOBAL_DIS   4
`define DPS_BIT_P1_ENABLE    6
`define DPS_BIT_P2_ENABLE    7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DPS_CTRL_RESET       8'h00
`define DPS_STATE_RESET      4'h1

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define DPS_SYNC_WIDTH       8
`define DPS_DETECT_CYCLES    2'h3

`endif

// *** logic/dps_sync.v ***
// Two-flop synchroniser for a group of asynchronous comparator and strap inputs.
`timescale 1ns/100ps

module dps_sync #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------------------
  // Per-bit double flop
  // --------------------------------------------------------------------------
  // The first stage feeds only the second stage, so a metastable sample never
  // reaches the selection logic.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate

endmodule

// *** logic/dps_path_selector.v ***
// Dual-input path selector: gate-driver control, path enables and status register.
`timescale 1ns/100ps
`include "dps_map.vh"

module dps_path_selector (
  input  wire       clk,
  input  wire       resetn,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       input1_undervoltage_fault,
  input  wire       input1_overvoltage_fault,
  input  wire       input2_undervoltage_fault,
  input  wire       input2_overvoltage_fault,
  input  wire       bus_rail_present,
  input  wire       bus_overcurrent_fault,
  input  wire       pair1_detect,
  input  wire       pair2_detect,
  output reg        path1_gate_driver,
  output reg        path2_gate_driver,
  output reg        converter_halt
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ON1  = 4'h2;
  localparam [3:0] ST_ON2  = 4'h4;
  localparam [3:0] ST_SWAP = 4'h8;

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  wire [`DPS_SYNC_WIDTH-1:0] sync_bits;

  dps_sync #(
    .WIDTH (`DPS_SYNC_WIDTH)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({pair2_detect, pair1_detect, bus_overcurrent_fault, bus_rail_present,
                input2_overvoltage_fault, input2_undervoltage_fault,
                input1_overvoltage_fault, input1_undervoltage_fault}),
    .sync_out (sync_bits)
  );

  wire s_uv1      = sync_bits[0];
  wire s_ov1      = sync_bits[1];
  wire s_uv2      = sync_bits[2];
  wire s_ov2      = sync_bits[3];
  wire s_bus      = sync_bits[4];
  wire s_oc       = sync_bits[5];
  wire s_det1     = sync_bits[6];
  wire s_det2     = sync_bits[7];

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg       path1_enable;
  reg       path2_enable;
  reg       path_disable_all;
  reg       high_impedance_mode;
  reg       global_path_disable;
  reg       path1_closed_status;
  reg       path2_closed_status;
  reg       fitted1;
  reg       fitted2;
  reg       det_done;
  reg [1:0] det_cnt;
  reg [3:0] state;
  reg       valid1_q;
  reg       valid2_q;

  reg       next_path1_enable;
  reg       next_path2_enable;
  reg       next_path_disable_all;
  reg       next_high_impedance_mode;
  reg       next_global_path_disable;
  reg       next_path1_closed_status;
  reg       next_path2_closed_status;
  reg       next_fitted1;
  reg       next_fitted2;
  reg       next_det_done;
  reg [1:0] next_det_cnt;
  reg [3:0] next_state;
  reg       next_gate1;
  reg       next_gate2;

  // --------------------------------------------------------------------------
  // Qualifiers
  // --------------------------------------------------------------------------
  wire valid1    = ~s_uv1 & ~s_ov1;
  wire valid2    = ~s_uv2 & ~s_ov2;
  wire dual      = fitted1 & fitted2;
  wire single    = fitted1 & ~fitted2;
  wire block_all = path_disable_all | global_path_disable | high_impedance_mode;
  wire ok1       = fitted1 & valid1 & ~block_all;
  wire ok2       = dual & valid2 & ~block_all;
  wire rise1     = det_done & valid1 & ~valid1_q;
  wire rise2     = det_done & valid2 & ~valid2_q;
  wire wr_ctrl   = reg_write & (reg_addr == `DPS_ADDR_PATH_CTRL);
  wire wr_en1    = reg_wdata[`DPS_BIT_P1_ENABLE];
  wire wr_en2    = reg_wdata[`DPS_BIT_P2_ENABLE];
  // Both high is never taken; both low only when two sources can be dropped.
  wire wr_pair_ok = (wr_en1 ^ wr_en2) | (~wr_en1 & ~wr_en2 & valid1 & valid2);

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always @* begin
    next_path1_enable        = path1_enable;
    next_path2_enable        = path2_enable;
    next_path_disable_all    = path_disable_all;
    next_high_impedance_mode = high_impedance_mode;
    next_global_path_disable = global_path_disable;
    next_path1_closed_status = path1_closed_status;
    next_path2_closed_status = path2_closed_status;
    next_fitted1             = fitted1;
    next_fitted2             = fitted2;
    next_det_done            = det_done;
    next_det_cnt             = det_cnt;
    next_state               = state;
    next_gate1               = 1'b0;
    next_gate2               = 1'b0;

    if (!det_done) begin
      // Straps are taken only after the synchroniser has filled.
      next_det_cnt = det_cnt + 2'h1;
      if (det_cnt == `DPS_DETECT_CYCLES) begin
        next_det_done = 1'b1;
        next_fitted1  = s_det1;
        next_fitted2  = s_det1 & s_det2;
        if (!s_det1) begin
          next_path_disable_all = 1'b1;
        end
        if (s_det1 & s_det2) begin
          next_path1_closed_status = 1'b1;
          next_path2_closed_status = 1'b1;
        end
      end
    end else begin
      if (wr_ctrl) begin
        next_path_disable_all    = reg_wdata[`DPS_BIT_DIS_ALL] | ~fitted1;
        next_high_impedance_mode = reg_wdata[`DPS_BIT_HIZ];
        next_global_path_disable = reg_wdata[`DPS_BIT_GLOBAL_DIS];
        if (single) begin
          next_path1_enable = wr_en1 & ~reg_wdata[`DPS_BIT_DIS_ALL];
        end else if (dual & wr_pair_ok) begin
          next_path1_enable = wr_en1;
          next_path2_enable = wr_en2;
        end
      end

      case (state)
        ST_IDLE: begin
          if (rise1 & ok1) begin
            next_path1_enable = 1'b1;
            next_path2_enable = 1'b0;
          end else if (rise2 & ok2 & ~(next_path1_enable & ok1)) begin
            next_path2_enable = 1'b1;
            next_path1_enable = 1'b0;
          end
          if (!s_bus) begin
            if (next_path1_enable & ok1) begin
              next_gate1 = 1'b1;
              next_state = ST_ON1;
            end else if (next_path2_enable & ok2) begin
              next_gate2 = 1'b1;
              next_state = ST_ON2;
            end
          end
        end
        ST_ON1: begin
          // A new input on path 2 is not acted on here.
          next_gate1 = 1'b1;
          if (~(next_path1_enable & ok1) | s_oc) begin
            next_gate1 = 1'b0;
            next_state = ST_SWAP;
            if ((~valid1 | s_oc) & ok2) begin
              next_path1_enable = 1'b0;
              next_path2_enable = 1'b1;
            end
          end
        end
        ST_ON2: begin
          next_gate2 = 1'b1;
          if (~(next_path2_enable & ok2) | s_oc) begin
            next_gate2 = 1'b0;
            next_state = ST_SWAP;
            if ((~valid2 | s_oc) & ok1) begin
              next_path2_enable = 1'b0;
              next_path1_enable = 1'b1;
            end
          end
        end
        ST_SWAP: begin
          // Both pairs stay open until the bus rail has discharged.
          if (!s_bus) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase

      if (!fitted2) begin
        next_path2_enable = 1'b0;
      end
      if (!fitted1) begin
        next_path1_enable = 1'b0;
      end
      // Any gate change refreshes both bits, so the detection value of the
      // pair that stays open is cleared as soon as the other pair closes.
      if ((next_gate1 != path1_gate_driver) | (next_gate2 != path2_gate_driver)) begin
        next_path1_closed_status = next_gate1;
        next_path2_closed_status = next_gate2 & fitted2;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      path1_enable        <= 1'b0;
      path2_enable        <= 1'b0;
      path_disable_all    <= 1'b0;
      high_impedance_mode <= 1'b0;
      global_path_disable <= 1'b0;
      path1_closed_status <= 1'b0;
      path2_closed_status <= 1'b0;
      fitted1             <= 1'b0;
      fitted2             <= 1'b0;
      det_done            <= 1'b0;
      det_cnt             <= 2'h0;
      state               <= `DPS_STATE_RESET;
      valid1_q            <= 1'b0;
      valid2_q            <= 1'b0;
      path1_gate_driver   <= 1'b0;
      path2_gate_driver   <= 1'b0;
      converter_halt      <= 1'b0;
    end else begin
      path1_enable        <= next_path1_enable;
      path2_enable        <= next_path2_enable;
      path_disable_all    <= next_path_disable_all;
      high_impedance_mode <= next_high_impedance_mode;
      global_path_disable <= next_global_path_disable;
      path1_closed_status <= next_path1_closed_status;
      path2_closed_status <= next_path2_closed_status;
      fitted1             <= next_fitted1;
      fitted2             <= next_fitted2;
      det_done            <= next_det_done;
      det_cnt             <= next_det_cnt;
      state               <= next_state;
      valid1_q            <= det_done ? valid1 : 1'b0;
      valid2_q            <= det_done ? valid2 : 1'b0;
      // Never both drivers at once, whatever the state machine asks.
      path1_gate_driver   <= next_gate1;
      path2_gate_driver   <= next_gate2 & ~next_gate1;
      converter_halt      <= (next_state == ST_SWAP);
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      if (reg_addr == `DPS_ADDR_PATH_CTRL) begin
        reg_rdata <= {path2_enable, path1_enable, 1'b0, global_path_disable,
                      high_impedance_mode, path_disable_all, path2_closed_status, path1_closed_status};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// *** testbench/dps_path_checker_props.sv ***
// Concurrent checks on the path selector ports.
`timescale 1ns/100ps

module dps_path_checker (
  input wire       clk,
  input wire       resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire       input1_undervoltage_fault,
  input wire       input1_overvoltage_fault,
  input wire       input2_undervoltage_fault,
  input wire       input2_overvoltage_fault,
  input wire       bus_rail_present,
  input wire       bus_overcurrent_fault,
  input wire       pair1_detect,
  input wire       pair2_detect,
  input wire       path1_gate_driver,
  input wire       path2_gate_driver,
  input wire       converter_halt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire g1   = path1_gate_driver;
  wire g2   = path2_gate_driver;
  wire wr13 = reg_write && reg_addr == 8'h13;
  wire f1   = input1_undervoltage_fault || input1_overvoltage_fault;
  wire f2   = input2_undervoltage_fault || input2_overvoltage_fault;
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  // Inputs pass two sync flops, so a pin is seen three edges before its effect.
  a_never_both: assert property (!(g1 && g2)) else $error("both pairs closed");
  a_on_conditions: assert property ($rose(g1) |-> !$past(bus_rail_present, 3)
    && !$past(f1, 3)) else $error("path 1 closed while blocked");
  a_halt_open: assert property (converter_halt |-> !g1 && !g2) else $error("pair closed in swap");
  a_halt_ends: assert property ($fell(converter_halt) |-> !$past(bus_rail_present, 3))
    else $error("swap ended with bus present");
  a_fault1_open: assert property (f1 [*3] |=> !g1) else $error("path 1 kept on fault");
  a_fault2_open: assert property (f2 [*3] |=> !g2) else $error("path 2 kept on fault");
  a_block_all: assert property (wr13 && (|reg_wdata[4:2]) |-> ##[1:2] (!g1 && !g2))
    else $error("drivers not forced off");
  a_zero_enables: assert property (wr13 && reg_wdata[7:6] == 2'h0 && !f1 && !f2
    |-> ##[1:2] (!g1 && !g2)) else $error("pairs kept on after enables cleared");
  a_status_read: assert property (reg_read && reg_addr == 8'h13 && (g1 || g2)
    |=> reg_rdata[1:0] == {$past(g2), $past(g1)}) else $error("status differs from gates");
  a_pair2_locked: assert property (!pair2_detect |-> !g2) else $error("absent pair driven");
  c_path1_on: cover property ($rose(g1));
  c_path2_on: cover property ($rose(g2));
  c_swap: cover property ($rose(converter_halt));
endmodule

bind dps_path_selector dps_path_checker dps_path_checker_i (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .input1_undervoltage_fault(input1_undervoltage_fault),
  .input1_overvoltage_fault(input1_overvoltage_fault), .input2_undervoltage_fault(input2_undervoltage_fault),
  .input2_overvoltage_fault(input2_overvoltage_fault), .bus_rail_present(bus_rail_present),
  .bus_overcurrent_fault(bus_overcurrent_fault), .pair1_detect(pair1_detect), .pair2_detect(pair2_detect),
  .path1_gate_driver(path1_gate_driver), .path2_gate_driver(path2_gate_driver),
  .converter_halt(converter_halt));

// *** testbench/dps_rail_model.sv ***
// Bus rail model fed by the two switch pairs and a direct source.
`timescale 1ns/100ps

module dps_rail_model #(
  parameter DROP = 5
) (
  input  wire clk,
  input  wire path1_gate_driver,
  input  wire path2_gate_driver,
  input  wire direct_source_on,
  output reg  bus_rail_present
);
  // The rail discharges slowly, so it stays present DROP cycles after every
  // feed is gone; a swap that does not wait for that would show overlap.
  integer hold_cnt;
  initial begin
    hold_cnt = 0;
    bus_rail_present = 1'b0;
  end
  always @(posedge clk) begin
    if (path1_gate_driver || path2_gate_driver || direct_source_on) begin
      hold_cnt <= DROP;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    bus_rail_present <= #2 (path1_gate_driver || path2_gate_driver || direct_source_on || hold_cnt > 1);
  end
endmodule

// *** testbench/dps_path_selector_test.sv ***
// Self-checking bench for the path selector.
`timescale 1ns/100ps

module dps_path_selector_test;
  reg        clk;
  reg        resetn;
  reg  [7:0] reg_addr;
  reg  [7:0] reg_wdata;
  reg        reg_write;
  reg        reg_read;
  wire [7:0] reg_rdata;
  reg        uv1;
  reg        ov1;
  reg        uv2;
  reg        ov2;
  reg        ovc;
  reg        det1;
  reg        det2;
  reg        direct_on;
  wire       bus_rail;
  wire       g1;
  wire       g2;
  wire       halt;
  integer    i;
  integer    n_mismatch;
  integer    num_checks;

  dps_path_selector dps_path_selector_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .input1_undervoltage_fault(uv1), .input1_overvoltage_fault(ov1), .input2_undervoltage_fault(uv2),
    .input2_overvoltage_fault(ov2), .bus_rail_present(bus_rail), .bus_overcurrent_fault(ovc),
    .pair1_detect(det1), .pair2_detect(det2), .path1_gate_driver(g1), .path2_gate_driver(g2),
    .converter_halt(halt));
  dps_rail_model dps_rail_model_i (.clk(clk), .path1_gate_driver(g1), .path2_gate_driver(g2),
    .direct_source_on(direct_on), .bus_rail_present(bus_rail));

  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task end_of_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk_reg(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      n_mismatch = n_mismatch + 1;
    end
  endtask
  // Waits up to n-1 cycles for the gate pair {path2, path1} to reach exp.
  task gates(input [1:0] exp, input integer n);
    for (i = 1; i < n && {g2, g1} !== exp; i = i + 1) begin
      tick(1);
    end
    num_checks = num_checks + 1;
    if ({g2, g1} !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, {g2, g1}, exp);
      n_mismatch = n_mismatch + 1;
      end_of_test;
    end
  endtask
  // Waits up to n cycles for the bus rail to fall below its present level.
  task bus_low(input integer n);
    for (i = 0; i < n && bus_rail !== 1'b0; i = i + 1) begin
      tick(1);
    end
    if (bus_rail !== 1'b0) begin
      chk_reg({7'h00, bus_rail}, 8'h00);
      end_of_test;
    end
  endtask
  task wr(input [7:0] d);
    tick(1);
    reg_addr = 8'h13;
    reg_wdata = d;
    reg_write = 1'b1;
    tick(1);
    reg_write = 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    tick(1);
    reg_addr = a;
    reg_read = 1'b1;
    tick(1);
    reg_read = 1'b0;
    chk_reg(reg_rdata, exp);
  endtask
  task rst(input p1, input p2);
    det1 = p1;
    det2 = p2;
    resetn = 1'b0;
    tick(6);
    resetn = 1'b1;
    tick(8);
  endtask

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial begin
    {clk, resetn, reg_addr, reg_wdata, reg_write, reg_read} = 20'h0;
    {uv1, ov1, uv2, ov2, ovc, direct_on} = 6'h28;
    n_mismatch = 0;
    num_checks = 0;
    rst(1'b1, 1'b1);
    rd(8'h13, 8'h03);
    rd(8'h12, 8'h00);
    {uv1, uv2} = 2'h0;
    gates(2'h1, 10);
    tick(8);
    gates(2'h1, 1);
    rd(8'h13, 8'h41);
    ov1 = 1'b1;
    gates(2'h2, 40);
    rd(8'h13, 8'h82);
    ov1 = 1'b0;
    tick(8);
    gates(2'h2, 1);
    wr(8'h40);
    gates(2'h1, 40);
    ovc = 1'b1;
    tick(4);
    ovc = 1'b0;
    gates(2'h2, 40);
    rd(8'h13, 8'h82);
    wr(8'hC0);
    tick(8);
    gates(2'h2, 1);
    rd(8'h13, 8'h82);
    wr(8'h00);
    gates(2'h0, 10);
    rd(8'h13, 8'h00);
    wr(8'h40);
    gates(2'h1, 40);
    uv2 = 1'b1;
    tick(8);
    wr(8'h00);
    tick(4);
    gates(2'h1, 1);
    rd(8'h13, 8'h41);
    // Disable-all, high impedance and global disable each force both drivers off.
    wr(8'h04);
    gates(2'h0, 4);
    rd(8'h13, 8'h44);
    wr(8'h48);
    tick(8);
    gates(2'h0, 1);
    wr(8'h50);
    tick(8);
    gates(2'h0, 1);
    wr(8'h40);
    gates(2'h1, 20);
    // Second reset in mid-run with only the first pair fitted.
    rst(1'b1, 1'b0);
    gates(2'h1, 4);
    rd(8'h13, 8'h41);
    wr(8'hC0);
    rd(8'h13, 8'h41);
    wr(8'h04);
    gates(2'h0, 4);
    rd(8'h13, 8'h04);
    bus_low(20);
    direct_on = 1'b1;
    tick(8);
    gates(2'h0, 1);
    direct_on = 1'b0;
    bus_low(20);
    wr(8'h40);
    gates(2'h1, 10);
    end_of_test;
  end
endmodule
